// file: design/host_sched_defines.svh
// Register offsets, field positions, reset values and timing counts for the
// host scheduler / programmed-I/O read register bank.
// Assumes a 200 MHz core clock and APB with 32-bit data.
// Functional notes
// (RULE1) Bit 2 set: process timed-stream area
// (RULE2) Bit 1 set: process periodic-poll area
// (RULE3) Bit 0 set: process asynchronous area
// (RULE4) 32-bit ms timeout raises enabled interrupt
// (RULE5) Timeout applies to completed async descriptors
// (RULE6) Latch start address, increment per bank read
// (RULE7) Software writes pointer before first read
// (RULE8) Bits 17:16 select one of four banks
// (RULE9) Bits 15:0 give read start address
// (RULE10) Software writes reserved bits with reset
// (RULE11) Flag set starts valid, unskipped descriptor walk
// (RULE12) Min gap between edge interrupts, microframes
// (RULE13) Edge pulse width in clocks, zero gives 16
`ifndef HOST_SCHED_DEFINES_SVH
`define HOST_SCHED_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define OFF_BUF_FILLED     12'h334
`define OFF_DONE_TIMEOUT   12'h338
`define OFF_PIO_POINTER    12'h33c
`define OFF_EDGE_SHAPING   12'h340
`define OFF_IRQ_CTRL       12'h348

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define BIT_ASYNC_FILL     0
`define BIT_PERIODIC_FILL  1
`define BIT_TIMED_FILL     2
`define BANK_LSB           16
`define BANK_MSB           17
`define ADDR_MSB           15
`define GAP_LSB            24
`define GAP_MSB            31
`define WIDTH_MSB          15
`define RST_EDGE_SHAPING   32'h0000_000f
`define RST_ZERO           32'h0000_0000
// Irq control: bit 0 timeout enable, bit 1 edge mode, bit 8 timeout status
`define BIT_TMO_EN         0
`define BIT_EDGE_MODE      1
`define BIT_TMO_STATUS     8

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ            200
`define MS_NS              1000000
`define CLK_NS             5
`define MS_CYCLES          (`MS_NS / `CLK_NS)
`define MICROFRAME_NS      125000
`define MICROFRAME_CYCLES  (`MICROFRAME_NS / `CLK_NS)
`define PULSE_BASE_MHZ     60
`define ZERO_WIDTH_CLOCKS  16
// 16 clocks of 60 MHz, rounded up to core clocks
`define ZERO_WIDTH_CYCLES  \
  ((`ZERO_WIDTH_CLOCKS * `CLK_MHZ + `PULSE_BASE_MHZ - 1) / `PULSE_BASE_MHZ)

`endif

// file: design/host_sched_pkg.sv
// Types shared by the scheduler register bank and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package host_sched_pkg;

  // APB request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

  // Scheduler area enables
  typedef struct packed {
    logic timed;
    logic periodic;
    logic async;
  } area_en_s;

  // Programmed-I/O read request from the memory side
  typedef struct packed {
    logic       valid;
    logic [1:0] bank;
  } pio_rd_s;

  typedef enum logic [1:0] {
    EDGE_IDLE,
    EDGE_PULSE,
    EDGE_GAP
  } edge_state_e;

endpackage : host_sched_pkg

// file: design/ms_timeout.sv
// Millisecond timeout for completed asynchronous descriptors.
// Assumes done_pending is a level from the scheduler.
`include "host_sched_defines.svh"
module ms_timeout #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        done_pending,
  input  wire logic [31:0] limit_ms,
  output logic             expired
);
  logic [31:0] tick_cnt;
  logic [31:0] ms_cnt;

  // ****************************************************************
  // Millisecond counting while completed async work waits
  // ****************************************************************
  // Only async done descriptors feed done_pending, others never count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 32'h0;
      ms_cnt   <= 32'h0;
      expired  <= 1'b0;
    end
    else if (ce)
    begin
      if (!done_pending)
      begin
        tick_cnt <= 32'h0; // RULE5
        ms_cnt   <= 32'h0;
        expired  <= 1'b0;
      end
      else if (ms_cnt >= limit_ms)
        expired <= 1'b1; // RULE4
      else if (tick_cnt == 32'(MS_CYCLES - 1))
      begin
        tick_cnt <= 32'h0;
        ms_cnt   <= ms_cnt + 32'h1;
      end
      else
        tick_cnt <= tick_cnt + 32'h1;
    end
  end
endmodule : ms_timeout

// file: design/edge_irq_shaper.sv
// Turns interrupt events into shaped edge pulses or a plain level.
// Assumes event_in is a one-cycle pulse or level from the core.
`include "host_sched_defines.svh"
module edge_irq_shaper #(
  parameter int UFRAME_CYCLES = `MICROFRAME_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        edge_mode,
  input  wire logic        event_in,
  input  wire logic [7:0]  min_gap,
  input  wire logic [15:0] pulse_clocks,
  output logic             irq
);
  host_sched_pkg::edge_state_e state;
  logic [31:0] cnt;
  logic [7:0]  gap_cnt;

  // ****************************************************************
  // Pulse and gap sequencing
  // ****************************************************************
  // Level mode bypasses the gap, as the gap only shapes edges
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state   <= host_sched_pkg::EDGE_IDLE;
      cnt     <= 32'h0;
      gap_cnt <= 8'h0;
      irq     <= 1'b0;
    end
    else if (ce)
    begin
      case (state)
        host_sched_pkg::EDGE_IDLE:
        begin
          irq <= !edge_mode && event_in;
          if (edge_mode && event_in)
          begin
            irq   <= 1'b1;
            state <= host_sched_pkg::EDGE_PULSE;
            cnt   <= (pulse_clocks == 16'h0) ?
                     32'(`ZERO_WIDTH_CYCLES - 1) :
                     32'(pulse_clocks) - 32'h1; // RULE13
          end
        end
        host_sched_pkg::EDGE_PULSE:
        begin
          if (cnt == 32'h0)
          begin
            irq     <= 1'b0;
            gap_cnt <= 8'h0;
            cnt     <= 32'h0;
            state   <= (min_gap == 8'h0) ? host_sched_pkg::EDGE_IDLE :
                       host_sched_pkg::EDGE_GAP; // RULE12
          end
          else
            cnt <= cnt - 32'h1;
        end
        host_sched_pkg::EDGE_GAP:
        begin
          if (gap_cnt >= min_gap)
            state <= host_sched_pkg::EDGE_IDLE; // RULE12
          else if (cnt == 32'(UFRAME_CYCLES - 1))
          begin
            cnt     <= 32'h0;
            gap_cnt <= gap_cnt + 8'h1;
          end
          else
            cnt <= cnt + 32'h1;
        end
        default:
          state <= host_sched_pkg::EDGE_IDLE;
      endcase
    end
  end
endmodule : edge_irq_shaper

// file: design/host_sched_pio_read_regs.sv
// APB register bank for scheduler area flags, async done timeout,
// programmed-I/O read pointers and edge interrupt shaping.
// Assumes an APB master on clk; the scheduler and memory side are logic.
`include "host_sched_defines.svh"
module host_sched_pio_read_regs #(
  parameter int MS_CYCLES     = `MS_CYCLES,
  parameter int UFRAME_CYCLES = `MICROFRAME_CYCLES,
  parameter int BANKS         = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire logic                     async_done_pending,
  input  wire host_sched_pkg::pio_rd_s  pio_rd,
  output host_sched_pkg::area_en_s      area_en,
  output logic [1:0]                    pio_bank,
  output logic [15:0]                   pio_addr,
  output logic                          irq
);
  logic [2:0]  buf_filled;
  logic [31:0] done_timeout;
  logic [1:0]  bank_sel;
  logic [15:0] bank_ptr [BANKS];
  logic [7:0]  min_gap;
  logic [15:0] pulse_clocks;
  logic [1:0]  irq_ctrl;
  logic        tmo_expired;
  logic        tmo_status;
  logic        wr_en;
  logic        rd_en;
  logic        shaped_irq;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFF_BUF_FILLED) || (a == `OFF_DONE_TIMEOUT) ||
             (a == `OFF_PIO_POINTER) || (a == `OFF_EDGE_SHAPING) ||
             (a == `OFF_IRQ_CTRL);
  endfunction : mapped

  // One-wait slave: the access acts on its first cycle, pready follows in the second
  assign wr_en = ce && psel && penable && pwrite && !pready;
  assign rd_en = ce && psel && penable && !pwrite && !pready;

  // Ready is a one-cycle pulse in the second access cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else if (ce)
      pready <= psel && penable && !pready;
  end

  // ****************************************************************
  // Read data and error
  // ****************************************************************
  // Reserved bits read back as constant zeros; nothing is stored for them
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pslverr <= (wr_en || rd_en) && !mapped(paddr);
      if (rd_en)
      begin
        case (paddr)
          `OFF_BUF_FILLED:   prdata <= {29'h0, buf_filled};
          `OFF_DONE_TIMEOUT: prdata <= done_timeout;
          `OFF_PIO_POINTER:  prdata <= {14'h0, bank_sel,
                                        bank_ptr[bank_sel]};
          `OFF_EDGE_SHAPING: prdata <= {min_gap, 8'h0, pulse_clocks};
          `OFF_IRQ_CTRL:     prdata <= {23'h0, tmo_status, 6'h0,
                                        irq_ctrl};
          default:           prdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Scheduler area flags
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      buf_filled <= 3'h0;
    else if (ce && wr_en && paddr == `OFF_BUF_FILLED)
      buf_filled <= pwdata[2:0];
  end

  // Each flag gates its area; a clear area is skipped entirely
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      area_en <= '0;
    else if (ce)
    begin
      area_en.timed    <= buf_filled[`BIT_TIMED_FILL]; // RULE1
      area_en.periodic <= buf_filled[`BIT_PERIODIC_FILL]; // RULE2
      area_en.async    <= buf_filled[`BIT_ASYNC_FILL]; // RULE3 RULE11
    end
  end

  // ****************************************************************
  // Timeout and shaping configuration
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      done_timeout <= `RST_ZERO;
      min_gap      <= 8'h0;
      pulse_clocks <= 16'(`RST_EDGE_SHAPING);
      irq_ctrl     <= 2'h0;
    end
    else if (ce && wr_en)
    begin
      if (paddr == `OFF_DONE_TIMEOUT)
        done_timeout <= pwdata; // RULE4
      if (paddr == `OFF_EDGE_SHAPING)
      begin
        min_gap      <= pwdata[`GAP_MSB:`GAP_LSB]; // RULE12
        pulse_clocks <= pwdata[`WIDTH_MSB:0]; // RULE13
      end
      if (paddr == `OFF_IRQ_CTRL)
        irq_ctrl <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // Programmed-I/O read pointers
  // ****************************************************************
  // A write reloads the chosen bank; reads advance only their own bank,
  // so interleaved banks keep independent sequences
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bank_sel <= 2'h0;
      for (int i = 0; i < BANKS; i++)
        bank_ptr[i] <= 16'h0;
    end
    else if (ce)
    begin
      if (pio_rd.valid)
        bank_ptr[pio_rd.bank] <= bank_ptr[pio_rd.bank] + 16'h1; // RULE6
      if (wr_en && paddr == `OFF_PIO_POINTER)
      begin
        bank_sel <= pwdata[`BANK_MSB:`BANK_LSB]; // RULE8
        bank_ptr[pwdata[`BANK_MSB:`BANK_LSB]] <=
          pwdata[`ADDR_MSB:0]; // RULE6 RULE9
      end
    end
  end

  // Address presented to the memory for the next read of the bank
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pio_bank <= 2'h0;
      pio_addr <= 16'h0;
    end
    else if (ce)
    begin
      pio_bank <= bank_sel; // RULE8
      pio_addr <= bank_ptr[bank_sel]; // RULE9
    end
  end

  // ****************************************************************
  // Timeout interrupt
  // ****************************************************************
  ms_timeout #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timeout (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .done_pending (async_done_pending),
    .limit_ms     (done_timeout),
    .expired      (tmo_expired)
  );

  // Sticky status; a new expiry in the clear cycle wins over the clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tmo_status <= 1'b0;
    else if (ce)
    begin
      if (tmo_expired && irq_ctrl[`BIT_TMO_EN])
        tmo_status <= 1'b1; // RULE4
      else if (wr_en && paddr == `OFF_IRQ_CTRL && pwdata[`BIT_TMO_STATUS])
        tmo_status <= 1'b0;
    end
  end

  edge_irq_shaper #(
    .UFRAME_CYCLES (UFRAME_CYCLES)
  ) u_shaper (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .edge_mode    (irq_ctrl[`BIT_EDGE_MODE]),
    .event_in     (tmo_status),
    .min_gap      (min_gap),
    .pulse_clocks (pulse_clocks),
    .irq          (shaped_irq)
  );

  // Registered output pin
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else if (ce)
      irq <= shaped_irq;
  end

endmodule : host_sched_pio_read_regs

// file: bench/regs_monitor.sv
// Checker for the scheduler register bank, bound to its ports.
// Assumes one clock domain and a synchronous active-low reset.
module regs_monitor (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    ce,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire logic                    async_done_pending,
  input wire host_sched_pkg::pio_rd_s pio_rd,
  input wire host_sched_pkg::area_en_s area_en,
  input wire logic [1:0]              pio_bank,
  input wire logic [15:0]             pio_addr,
  input wire logic                    irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Helpers and properties
  // ****************************************************************
  logic        taken;
  logic [31:0] wd_q;

  // Access edge as the slave sees it; write data kept for later checks
  assign taken = psel && penable && !pready && ce;
  always_ff @(posedge clk)
  begin
    if (taken && pwrite)
      wd_q <= pwdata;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  ready_follows_a: assert property (taken |=> pready)
    else $error("no pready after access edge");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  refused_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  area_flags_a: assert property (
    taken && pwrite && paddr == 12'h334 |=> ##[0:1] area_en == wd_q[2:0])
    else $error("area enables differ from written flags");
  pio_load_a: assert property (
    taken && pwrite && paddr == 12'h33c |=> ##[0:1]
    {pio_bank, pio_addr} == wd_q[17:0])
    else $error("pointer load wrong");
  pio_step_a: assert property (
    ce && pio_rd.valid && pio_rd.bank == pio_bank &&
    !$past(pio_rd.valid) && $stable(pio_addr) && !taken |=> ##1
    pio_addr == $past(pio_addr, 2) + 16'h1)
    else $error("pointer did not step by one");
  reserved_zero_a: assert property (
    pready && !pwrite && !pslverr && paddr == 12'h33c |->
    prdata[31:18] == 14'h0)
    else $error("reserved pointer bits not zero");
  // Low clock enable must freeze every registered output
  freeze_hold_a: assert property (!ce |=> $stable({pready, prdata, pslverr,
    area_en, pio_bank, pio_addr, irq}))
    else $error("state moved while clock enable low");

  // Main scenarios reached
  cover property (taken && pwrite && paddr == 12'h334);
  cover property (pio_rd.valid);
  cover property ($rose(irq));
endmodule : regs_monitor

bind host_sched_pio_read_regs regs_monitor mon (
  .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr),
  .async_done_pending(async_done_pending), .pio_rd(pio_rd),
  .area_en(area_en), .pio_bank(pio_bank), .pio_addr(pio_addr), .irq(irq)
);

// file: bench/sched_side_model.sv
// Scheduler and memory side: read pulses and the async-done level.
// Assumes the bench calls its tasks from a single process.
module sched_side_model (
  input  wire logic               clk,
  output host_sched_pkg::pio_rd_s pio_rd,
  output logic                    async_done_pending
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet at start so nothing moves a pointer before software sets it
  initial
  begin
    pio_rd = '0;
    async_done_pending = 1'b0;
  end

  // One read: a single-cycle pulse, then a quiet cycle
  task read_bank(input logic [1:0] b);
    @(posedge clk);
    pio_rd <= '{valid: 1'b1, bank: b};
    @(posedge clk);
    pio_rd <= '0;
  endtask : read_bank

  task set_pending(input logic v);
    @(posedge clk);
    async_done_pending <= v;
  endtask : set_pending
endmodule : sched_side_model

// file: bench/host_sched_pio_read_regs_tb.sv
// Self-checking bench for the scheduler register bank over APB.
// Assumes short ms and microframe counts passed as parameters.
module host_sched_pio_read_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  pio_bank;
  logic [15:0] pio_addr;
  logic        async_done_pending;
  host_sched_pkg::pio_rd_s  pio_rd;
  host_sched_pkg::area_en_s area_en;
  int errors, checks, hi, lo;
  logic [11:0] offs [5] = '{12'h334, 12'h338, 12'h33c, 12'h340, 12'h348};
  logic [31:0] rstv [5] = '{0, 0, 0, 32'hf, 0};
  logic [31:0] flags [5] = '{1, 2, 4, 7, 0};

  host_sched_pio_read_regs #(.MS_CYCLES(10), .UFRAME_CYCLES(5))
  uut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .async_done_pending(async_done_pending), .pio_rd(pio_rd),
    .area_en(area_en), .pio_bank(pio_bank), .pio_addr(pio_addr), .irq(irq)
  );

  sched_side_model sched (
    .clk(clk), .pio_rd(pio_rd), .async_done_pending(async_done_pending)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task test_done;
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      check("pready", 1, pready);
      test_done;
    end
  endtask : apb

  task wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    if (irq !== 1'b1)
    begin
      check("irq", 1, irq);
      test_done;
    end
  endtask : wait_irq

  // Cycles irq stays high from its first high edge, then stays low
  task pulse_shape;
    hi = 0;
    while (irq === 1'b1 && hi < 100)
    begin
      @(posedge clk);
      hi++;
    end
    lo = 0;
    while (irq !== 1'b1 && lo < 100)
    begin
      @(posedge clk);
      lo++;
    end
  endtask : pulse_shape

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 0);
      check("reset value", rstv[i], rd);
    end
    // Reserved bits always written as zero
    foreach (flags[i])
    begin
      apb(1'b1, 12'h334, flags[i]);
      @(posedge clk);
      check("area_en", flags[i], {29'h0, area_en});
      apb(1'b0, 12'h334, 0);
      check("flags", flags[i], rd);
    end
    apb(1'b1, 12'h338, 32'hdead_beef);
    apb(1'b0, 12'h338, 0);
    check("timeout reg", 32'hdead_beef, rd);
    // Each bank wraps past ffff; a read of the next bank must not leak
    for (int b = 0; b < 4; b++)
    begin
      apb(1'b1, 12'h33c, {14'h0, 2'(b), 16'hfffe});
      repeat (3) sched.read_bank(2'(b));
      sched.read_bank(2'(b + 1));
      repeat (3) @(posedge clk);
      apb(1'b0, 12'h33c, 0);
      check("pointer", {14'h0, 2'(b), 16'h1}, rd);
      check("pio out", {14'h0, 2'(b), 16'h1},
            {14'h0, pio_bank, pio_addr});
    end
    // Frozen clock enable: a read pulse must leave the pointer alone
    ce <= 1'b0;
    sched.read_bank(2'h3);
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    apb(1'b0, 12'h33c, 0);
    check("frozen pointer", {14'h0, 2'h3, 16'h1}, rd);
    apb(1'b0, 12'h350, 0);
    check("unmapped data", 0, rd);
    check("slverr", 1, err);
    // Level timeout: 2 ms of 10 cycles each
    apb(1'b1, 12'h338, 2);
    apb(1'b1, 12'h348, 1);
    sched.set_pending(1'b1);
    repeat (12) @(posedge clk);
    check("irq early", 0, irq);
    wait_irq(40);
    apb(1'b0, 12'h348, 0);
    check("status", 32'h101, rd);
    sched.set_pending(1'b0);
    apb(1'b1, 12'h348, 32'h101);
    repeat (40) @(posedge clk);
    check("irq idle", 0, irq);
    // Edge mode: 3-clock pulse, gap of one microframe
    apb(1'b1, 12'h340, 32'h0100_0003);
    apb(1'b1, 12'h348, 3);
    sched.set_pending(1'b1);
    wait_irq(60);
    pulse_shape;
    check("pulse width", 3, hi);
    check("gap", 1, lo >= 5 && lo < 100);
    // Clear, then zero width and zero gap: width 0 gives 54 core clocks
    sched.set_pending(1'b0);
    apb(1'b1, 12'h348, 32'h103);
    repeat (20) @(posedge clk);
    check("irq cleared", 0, irq);
    apb(1'b1, 12'h340, 0);
    sched.set_pending(1'b1);
    wait_irq(60);
    pulse_shape;
    check("default width", 54, hi);
    check("no gap", 1, lo < 5);
    sched.set_pending(1'b0);
    test_done;
  end
endmodule : host_sched_pio_read_regs_tb
